/* File: inc/psqid_regs.vh */
// constants for the pulse sequencer instruction decoder
`ifndef PSQID_REGS_VH
`define PSQID_REGS_VH
`define PSQID_HDR_MSB 63
`define PSQID_HDR_LSB 56
`define PSQID_OP_MSB 63
`define PSQID_OP_LSB 60
`define PSQID_ENG_MSB 59
`define PSQID_ENG_LSB 58
`define PSQID_WR_BIT 56
`define PSQID_OP_WAVE 4'h0
`define PSQID_OP_MARK 4'h1
`define PSQID_OP_WAIT 4'h2
`define PSQID_OP_LDREP 4'h3
`define PSQID_OP_REP 4'h4
`define PSQID_OP_CMP 4'h5
`define PSQID_OP_BRANCH 4'h6
`define PSQID_OP_CALL 4'h7
`define PSQID_OP_RET 4'h8
`define PSQID_OP_SYNC 4'h9
`define PSQID_OP_MOD 4'hA
`define PSQID_OP_LDCMP 4'hB
`define PSQID_OP_IPF 4'hC
`define PSQID_EOP_MSB 47
`define PSQID_EOP_LSB 46
`define PSQID_EOP_PLAY 2'h0
`define PSQID_EOP_TRIG 2'h1
`define PSQID_EOP_SYNC 2'h2
`define PSQID_EOP_PF 2'h3
`define PSQID_TA_BIT 45
`define PSQID_WCNT_MSB 44
`define PSQID_WCNT_LSB 24
`define PSQID_WADR_MSB 23
`define PSQID_WADR_LSB 0
`define PSQID_TRW_MSB 36
`define PSQID_TRW_LSB 33
`define PSQID_LVL_BIT 32
`define PSQID_MOP_MSB 47
`define PSQID_MOP_LSB 45
`define PSQID_NSEL_MSB 43
`define PSQID_NSEL_LSB 40
`define PSQID_ARG_MSB 31
`define PSQID_ARG_LSB 0
`define PSQID_TGT_MSB 25
`define PSQID_TGT_LSB 0
`define PSQID_REPV_MSB 15
`define PSQID_REPV_LSB 0
`define PSQID_CMPOP_MSB 9
`define PSQID_CMPOP_LSB 8
`define PSQID_MASK_MSB 7
`define PSQID_MASK_LSB 0
`define PSQID_CMP_EQ 2'h0
`define PSQID_CMP_NE 2'h1
`define PSQID_CMP_GT 2'h2
`define PSQID_CMP_LT 2'h3
`define PSQID_WPF_SAMPLES 32'h00010000
`define PSQID_IPF_LINE 8'h80
`define PSQID_APB_CTRL 12'h000
`define PSQID_APB_STAT 12'h004
`define PSQID_APB_IP 12'h008
`define PSQID_APB_CREG 12'h00C
`define PSQID_APB_REPC 12'h010
`define PSQID_APB_START 12'h014
`endif

/* File: core/psqid_stack.v */
// return stack holding instruction pointer and repeat counter pairs
module psqid_stack #(
  parameter AW = 26,
  parameter RW = 16,
  parameter DEPTH_LOG2 = 4
) (
  input wire clk,
  input wire nrst,
  input wire clr,
  input wire push,
  input wire pop,
  input wire [AW-1:0] push_ip,
  input wire [RW-1:0] push_rep,
  output wire [AW-1:0] top_ip,
  output wire [RW-1:0] top_rep,
  output wire empty,
  output wire full
);
  // ==========================================
  // storage
  reg [AW+RW-1:0] mem [0:(1<<DEPTH_LOG2)-1];
  reg [DEPTH_LOG2:0] cnt_q;
  wire [DEPTH_LOG2-1:0] top_idx;
  assign top_idx = cnt_q[DEPTH_LOG2-1:0] - {{(DEPTH_LOG2-1){1'b0}}, 1'b1};
  assign empty = (cnt_q == {(DEPTH_LOG2+1){1'b0}});
  assign full = cnt_q[DEPTH_LOG2];
  assign top_ip = mem[top_idx][AW+RW-1:RW];
  assign top_rep = mem[top_idx][RW-1:0];
  always @(posedge clk) begin
    if (push && !full) begin
      mem[cnt_q[DEPTH_LOG2-1:0]] <= {push_ip, push_rep};
    end
  end
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= {(DEPTH_LOG2+1){1'b0}};
    end else if (clr) begin
      cnt_q <= {(DEPTH_LOG2+1){1'b0}};
    end else if (push && !full) begin
      cnt_q <= cnt_q + {{DEPTH_LOG2{1'b0}}, 1'b1};
    end else if (pop && !empty) begin
      cnt_q <= cnt_q - {{DEPTH_LOG2{1'b0}}, 1'b1};
    end
  end
endmodule

/* File: core/psqid_decode.v */
// instruction decoder and dispatcher of the pulse sequencer
// What this block does
// - 64-bit word, header bits 63-56, payload 55-0 chosen by op code.
// - header carries type, engine select, reserved bit, group write flag.
// - repeat decrements counter, jumps only while result above zero.
// - call pushes ip and repeat counter; return pops both.
// - waveform bits 47-46: play, wait trigger, wait sync, prefetch.
// - play outputs memory from address 23-0 for count 44-24.
// - time/amplitude flag bit 45 holds one address constant.
// - wait operations stall the engine until trigger or sync arrives.
// - waveform prefetch loads 64k samples into the pending cache bank.
// - marker payload: op, transition word, level, 32-bit count.
// - marker holds level for count, then emits 4-bit transition word.
// - marker waits behave exactly like waveform waits.
// - compare tests 8-bit register against mask with eq, ne, gt, lt.
// - latest compare result gates only the next branch, call or return.
// - load-compare pops message queue, stalls while queue empty.
// - load-compare and return ignore all payload bits.
// - branch, call, repeat take target from bits 25-0.
// - load-repeat puts 16-bit count in counter; software loads N for N passes.
// - instruction prefetch fetches a 128-word line into subroutine cache.
// - modulator payload: op 47-45, nco mask 43-40, operand 31-0.
// - modulator ops: modulate, reset, wait, incr, sync, offset, frame.
// - two oscillators, one mask bit each; 0011 targets both.
// - phase operands are UQ2.28 fractions applied per system clock.
//
// Chosen here: the APB register port and the register offsets.
`include "psqid_regs.vh"
module psqid_decode #(
  parameter AW = 26,
  parameter RW = 16,
  parameter STACK_LOG2 = 4,
  parameter NCO_N = 2
) (
  input wire clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire [AW-1:0] fetch_addr,
  output wire fetch_req,
  input wire fetch_valid,
  input wire [63:0] fetch_data,
  output reg icache_pf_valid,
  output reg [AW-1:0] icache_pf_addr,
  output reg [7:0] icache_pf_len,
  input wire msg_valid,
  input wire [7:0] msg_data,
  output wire msg_pop,
  output reg wf_valid,
  output reg [1:0] wf_op,
  output reg wf_hold,
  output reg [20:0] wf_count,
  output reg [23:0] wf_addr,
  output reg [31:0] wf_pf_len,
  input wire wf_ready,
  output reg mk_valid,
  output reg [1:0] mk_chan,
  output reg [1:0] mk_op,
  output reg [3:0] mk_trans,
  output reg mk_level,
  output reg [31:0] mk_count,
  input wire mk_ready,
  output reg md_valid,
  output reg [2:0] md_op,
  output reg [NCO_N-1:0] md_nco,
  output reg [31:0] md_arg,
  input wire md_ready,
  output reg group_flush,
  input wire engines_idle
);
  // ==========================================
  // helpers
  function cmp_eval;
    input [1:0] op;
    input [7:0] a;
    input [7:0] m;
    begin
      case (op)
        `PSQID_CMP_EQ: cmp_eval = (a == m);
        `PSQID_CMP_NE: cmp_eval = (a != m);
        `PSQID_CMP_GT: cmp_eval = (a > m);
        default: cmp_eval = (a < m);
      endcase
    end
  endfunction
  function [AW-1:0] next_ip;
    input [AW-1:0] ip;
    begin
      next_ip = ip + {{(AW-1){1'b0}}, 1'b1};
    end
  endfunction

  // ==========================================
  // state
  localparam ST_IDLE = 2'h0;
  localparam ST_FETCH = 2'h1;
  localparam ST_EXEC = 2'h2;
  localparam ST_SYNC = 2'h3;
  reg [1:0] st_q;
  reg [AW-1:0] ip_q;
  reg [RW-1:0] rep_q;
  reg [7:0] creg_q;
  reg cond_q;
  reg [63:0] ir_q;
  reg run_q;
  reg [AW-1:0] start_q;
  reg start_pend_q;

  // ==========================================
  // fields
  wire [3:0] op = ir_q[`PSQID_OP_MSB:`PSQID_OP_LSB];
  wire [1:0] eng = ir_q[`PSQID_ENG_MSB:`PSQID_ENG_LSB];
  wire wflag = ir_q[`PSQID_WR_BIT];
  wire [55:0] pl = ir_q[55:0];
  wire [AW-1:0] tgt = pl[`PSQID_TGT_MSB:`PSQID_TGT_LSB];
  wire [RW-1:0] rep_dec = rep_q - {{(RW-1){1'b0}}, 1'b1};

  // ==========================================
  // stack
  wire stk_push;
  wire stk_pop;
  wire [AW-1:0] stk_ip;
  wire [RW-1:0] stk_rep;
  wire stk_empty;
  wire stk_full;
  psqid_stack #(.AW(AW), .RW(RW), .DEPTH_LOG2(STACK_LOG2)) u_stack (
    .clk(clk),
    .nrst(nrst),
    .clr(start_pend_q),
    .push(stk_push),
    .pop(stk_pop),
    .push_ip(next_ip(ip_q)),
    .push_rep(rep_q),
    .top_ip(stk_ip),
    .top_rep(stk_rep),
    .empty(stk_empty),
    .full(stk_full)
  );

  // ==========================================
  // stall decision
  wire in_exec = (st_q == ST_EXEC);
  reg eng_ok;
  always @* begin
    case (op)
      `PSQID_OP_WAVE: eng_ok = wf_ready || !wf_valid;
      `PSQID_OP_MARK: eng_ok = mk_ready || !mk_valid;
      `PSQID_OP_MOD: eng_ok = md_ready || !md_valid;
      `PSQID_OP_WAIT: eng_ok = (wf_ready || !wf_valid) && (mk_ready || !mk_valid);
      `PSQID_OP_SYNC: eng_ok = (wf_ready || !wf_valid) && (mk_ready || !mk_valid);
      `PSQID_OP_LDCMP: eng_ok = msg_valid;
      `PSQID_OP_IPF: eng_ok = !icache_pf_valid;
      default: eng_ok = 1'b1;
    endcase
  end
  wire fire = in_exec && eng_ok;
  assign msg_pop = fire && (op == `PSQID_OP_LDCMP);
  wire take_cond = cond_q;
  assign stk_push = fire && (op == `PSQID_OP_CALL) && take_cond && !stk_full;
  assign stk_pop = fire && (op == `PSQID_OP_RET) && take_cond && !stk_empty;
  assign fetch_req = (st_q == ST_FETCH);
  assign fetch_addr = ip_q;

  // ==========================================
  // flow control
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      ip_q <= {AW{1'b0}};
      rep_q <= {RW{1'b0}};
      creg_q <= 8'h00;
      cond_q <= 1'b1;
      ir_q <= 64'h0000000000000000;
    end else if (start_pend_q) begin
      st_q <= ST_FETCH;
      ip_q <= start_q;
      cond_q <= 1'b1;
    end else if (!run_q) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_FETCH: begin
          if (fetch_valid) begin
            ir_q <= fetch_data;
            st_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (fire) begin
            st_q <= (op == `PSQID_OP_SYNC) ? ST_SYNC : ST_FETCH;
            ip_q <= next_ip(ip_q);
            case (op)
              `PSQID_OP_LDREP: rep_q <= pl[`PSQID_REPV_MSB:`PSQID_REPV_LSB];
              `PSQID_OP_REP: begin
                rep_q <= rep_dec;
                if (rep_dec != {RW{1'b0}}) begin
                  ip_q <= tgt;
                end
              end
              `PSQID_OP_CMP: begin
                cond_q <= cmp_eval(pl[`PSQID_CMPOP_MSB:`PSQID_CMPOP_LSB], creg_q,
                  pl[`PSQID_MASK_MSB:`PSQID_MASK_LSB]);
              end
              `PSQID_OP_LDCMP: creg_q <= msg_data;
              `PSQID_OP_BRANCH: begin
                if (take_cond) begin
                  ip_q <= tgt;
                end
                cond_q <= 1'b1;
              end
              `PSQID_OP_CALL: begin
                if (take_cond) begin
                  ip_q <= tgt;
                end
                cond_q <= 1'b1;
              end
              `PSQID_OP_RET: begin
                if (take_cond && !stk_empty) begin
                  ip_q <= stk_ip;
                  rep_q <= stk_rep;
                end
                cond_q <= 1'b1;
              end
              default: begin
              end
            endcase
          end
        end
        ST_SYNC: begin
          if (engines_idle && !wf_valid && !mk_valid && !md_valid) begin
            st_q <= ST_FETCH;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // engine dispatch
  wire eng_fire = fire && (op == `PSQID_OP_WAVE || op == `PSQID_OP_WAIT || op == `PSQID_OP_SYNC);
  wire mk_fire = fire && (op == `PSQID_OP_MARK || op == `PSQID_OP_WAIT || op == `PSQID_OP_SYNC);
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wf_valid <= 1'b0;
      wf_op <= 2'h0;
      wf_hold <= 1'b0;
      wf_count <= 21'h000000;
      wf_addr <= 24'h000000;
      wf_pf_len <= 32'h00000000;
      mk_valid <= 1'b0;
      mk_chan <= 2'h0;
      mk_op <= 2'h0;
      mk_trans <= 4'h0;
      mk_level <= 1'b0;
      mk_count <= 32'h00000000;
      md_valid <= 1'b0;
      md_op <= 3'h0;
      md_nco <= {NCO_N{1'b0}};
      md_arg <= 32'h00000000;
      icache_pf_valid <= 1'b0;
      icache_pf_addr <= {AW{1'b0}};
      icache_pf_len <= 8'h00;
      group_flush <= 1'b0;
    end else begin
      if (wf_ready) begin
        wf_valid <= 1'b0;
      end
      if (mk_ready) begin
        mk_valid <= 1'b0;
      end
      if (md_ready) begin
        md_valid <= 1'b0;
      end
      icache_pf_valid <= 1'b0;
      group_flush <= fire && wflag && (eng_fire || mk_fire);
      if (eng_fire && op != `PSQID_OP_MARK) begin
        wf_valid <= 1'b1;
        wf_op <= pl[`PSQID_EOP_MSB:`PSQID_EOP_LSB];
        wf_hold <= pl[`PSQID_TA_BIT];
        wf_count <= pl[`PSQID_WCNT_MSB:`PSQID_WCNT_LSB];
        wf_addr <= pl[`PSQID_WADR_MSB:`PSQID_WADR_LSB];
        wf_pf_len <= (pl[`PSQID_EOP_MSB:`PSQID_EOP_LSB] == `PSQID_EOP_PF) ?
          `PSQID_WPF_SAMPLES : 32'h00000000;
      end
      if (mk_fire && op != `PSQID_OP_WAVE) begin
        mk_valid <= 1'b1;
        mk_chan <= eng;
        mk_op <= pl[`PSQID_EOP_MSB:`PSQID_EOP_LSB];
        mk_trans <= pl[`PSQID_TRW_MSB:`PSQID_TRW_LSB];
        mk_level <= pl[`PSQID_LVL_BIT];
        mk_count <= pl[31:0];
      end
      if (fire && op == `PSQID_OP_MOD) begin
        md_valid <= 1'b1;
        md_op <= pl[`PSQID_MOP_MSB:`PSQID_MOP_LSB];
        md_nco <= pl[`PSQID_NSEL_LSB+NCO_N-1:`PSQID_NSEL_LSB];
        md_arg <= pl[`PSQID_ARG_MSB:`PSQID_ARG_LSB];
      end
      if (fire && op == `PSQID_OP_IPF) begin
        icache_pf_valid <= 1'b1;
        icache_pf_addr <= tgt;
        icache_pf_len <= `PSQID_IPF_LINE;
      end
    end
  end

  // ==========================================
  // apb registers
  wire apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  reg addr_ok;
  always @* begin
    case (paddr)
      `PSQID_APB_CTRL, `PSQID_APB_STAT, `PSQID_APB_IP, `PSQID_APB_CREG, `PSQID_APB_REPC,
      `PSQID_APB_START: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= 1'b0;
      start_q <= {AW{1'b0}};
      start_pend_q <= 1'b0;
    end else begin
      start_pend_q <= 1'b0;
      if (apb_wr && paddr == `PSQID_APB_CTRL) begin
        run_q <= pwdata[0];
        start_pend_q <= pwdata[0] && !run_q;
      end
      if (apb_wr && paddr == `PSQID_APB_START) begin
        start_q <= pwdata[AW-1:0];
      end
    end
  end
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      case (paddr)
        `PSQID_APB_CTRL: prdata <= {31'h00000000, run_q};
        `PSQID_APB_STAT: prdata <= {24'h000000, stk_full, stk_empty, 1'b0, cond_q, 2'h0, st_q};
        `PSQID_APB_IP: prdata <= {{(32-AW){1'b0}}, ip_q};
        `PSQID_APB_CREG: prdata <= {24'h000000, creg_q};
        `PSQID_APB_REPC: prdata <= {{(32-RW){1'b0}}, rep_q};
        `PSQID_APB_START: prdata <= {{(32-AW){1'b0}}, start_q};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule

/* File: tb/psqid_assertions.sv */
// port checker of the instruction decoder
module psqid_assertions #(
  parameter AW = 26
) (
  input wire clk,
  input wire nrst,
  input wire [AW-1:0] fetch_addr,
  input wire fetch_req,
  input wire fetch_valid,
  input wire icache_pf_valid,
  input wire [7:0] icache_pf_len,
  input wire msg_valid,
  input wire msg_pop,
  input wire wf_valid,
  input wire [1:0] wf_op,
  input wire [20:0] wf_count,
  input wire [23:0] wf_addr,
  input wire [31:0] wf_pf_len,
  input wire wf_ready,
  input wire mk_valid,
  input wire [1:0] mk_op,
  input wire [31:0] mk_count,
  input wire mk_ready,
  input wire md_valid,
  input wire [31:0] md_arg,
  input wire md_ready,
  input wire group_flush
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // =====================================
  // engine requests
  property p_wf_hold;
    wf_valid && !wf_ready |=> wf_valid && $stable({wf_op, wf_count, wf_addr});
  endproperty
  a_wf_hold: assert property (p_wf_hold) else $error("waveform request changed");
  property p_mk_hold;
    mk_valid && !mk_ready |=> mk_valid && $stable({mk_op, mk_count});
  endproperty
  a_mk_hold: assert property (p_mk_hold) else $error("marker request changed");
  property p_md_hold;
    md_valid && !md_ready |=> md_valid && $stable(md_arg);
  endproperty
  a_md_hold: assert property (p_md_hold) else $error("modulator request changed");
  property p_pf_len;
    wf_valid && wf_op == 2'h3 |-> wf_pf_len == 32'h00010000;
  endproperty
  a_pf_len: assert property (p_pf_len) else $error("prefetch length wrong");
  property p_wait_both;
    $rose(wf_valid) && wf_op == 2'h1 |-> mk_valid && mk_op == 2'h1;
  endproperty
  a_wait_both: assert property (p_wait_both) else $error("wait not sent to marker");
  // =====================================
  // side channels
  property p_ipf;
    icache_pf_valid |-> icache_pf_len == 8'h80 ##1 !icache_pf_valid;
  endproperty
  a_ipf: assert property (p_ipf) else $error("line prefetch wrong");
  property p_pop;
    msg_pop |-> msg_valid;
  endproperty
  a_pop: assert property (p_pop) else $error("pop of empty queue");
  property p_flush;
    group_flush |=> !group_flush;
  endproperty
  a_flush: assert property (p_flush) else $error("flush not a pulse");
  property p_fetch;
    fetch_req && !fetch_valid |=> fetch_req && $stable(fetch_addr);
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch request changed");
endmodule

bind psqid_decode psqid_assertions #(.AW(AW)) chk_u (
  .clk(clk), .nrst(nrst), .fetch_addr(fetch_addr), .fetch_req(fetch_req), .fetch_valid(fetch_valid),
  .icache_pf_valid(icache_pf_valid), .icache_pf_len(icache_pf_len), .msg_valid(msg_valid),
  .msg_pop(msg_pop), .wf_valid(wf_valid), .wf_op(wf_op), .wf_count(wf_count), .wf_addr(wf_addr),
  .wf_pf_len(wf_pf_len), .wf_ready(wf_ready), .mk_valid(mk_valid), .mk_op(mk_op), .mk_count(mk_count),
  .mk_ready(mk_ready), .md_valid(md_valid), .md_arg(md_arg), .md_ready(md_ready),
  .group_flush(group_flush)
);

/* File: tb/psqid_engine_model.sv */
// execution engine partner model
module psqid_engine_model (
  input wire clk,
  input wire nrst,
  input wire slow,
  input wire wf_valid,
  input wire mk_valid,
  output wire wf_ready,
  output wire mk_ready,
  output wire md_ready,
  output wire engines_idle
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;
  logic [2:0] busy_q;
  wire go = !slow || cnt_q == 2'h0;
  // slow mode accepts one cycle in four
  assign wf_ready = go;
  assign mk_ready = go;
  assign md_ready = go;
  // engines drain a few cycles after their last request
  assign engines_idle = busy_q == 3'h0 && !wf_valid && !mk_valid;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 2'h0;
      busy_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      if ((wf_valid && wf_ready) || (mk_valid && mk_ready)) busy_q <= 3'h5;
      else if (busy_q != 3'h0) busy_q <= busy_q - 3'h1;
    end
  end
endmodule

/* File: tb/tb.sv */
// testbench of the instruction decoder
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, fetch_valid = 0, msg_valid = 0, slow = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, r;
  logic [63:0] fetch_data = 0, imem[64];
  logic [7:0] msg_data = 0;
  logic e;
  logic [31:0] pf_seen = 0;
  wire [31:0] prdata, wf_pf_len, mk_count, md_arg;
  wire [25:0] fetch_addr, icache_pf_addr;
  wire [7:0] icache_pf_len;
  wire [1:0] wf_op, mk_chan, mk_op, md_nco;
  wire [20:0] wf_count;
  wire [23:0] wf_addr;
  wire [3:0] mk_trans;
  wire [2:0] md_op;
  wire pready, pslverr, fetch_req, icache_pf_valid, msg_pop, wf_valid, wf_hold, wf_ready, mk_valid;
  wire mk_level, mk_ready, md_valid, md_ready, group_flush, engines_idle;
  int errors = 0, checks = 0, cyc = 0, gn = 0;
  logic [47:0] wq[$];
  logic [40:0] mq[$];
  logic [36:0] dq[$];
  logic [33:0] iq[$];
  logic [47:0] wx[6] = '{{2'h0, 1'b1, 21'h5, 24'h123456}, {2'h1, 46'h0}, {2'h2, 46'h0},
    {2'h0, 1'b0, 21'h7, 24'h10}, {2'h0, 1'b0, 21'h7, 24'h10}, {2'h3, 1'b0, 21'h0, 24'h200}};
  logic [40:0] mx[3] = '{{2'h0, 2'h2, 4'hA, 1'b1, 32'h12345678}, {2'h1, 39'h0}, {2'h2, 39'h0}};
  always #2 clk = ~clk;
  psqid_decode dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_addr(fetch_addr), .fetch_req(fetch_req), .fetch_valid(fetch_valid), .fetch_data(fetch_data),
    .icache_pf_valid(icache_pf_valid), .icache_pf_addr(icache_pf_addr), .icache_pf_len(icache_pf_len),
    .msg_valid(msg_valid), .msg_data(msg_data), .msg_pop(msg_pop), .wf_valid(wf_valid), .wf_op(wf_op),
    .wf_hold(wf_hold), .wf_count(wf_count), .wf_addr(wf_addr), .wf_pf_len(wf_pf_len),
    .wf_ready(wf_ready), .mk_valid(mk_valid), .mk_chan(mk_chan), .mk_op(mk_op), .mk_trans(mk_trans),
    .mk_level(mk_level), .mk_count(mk_count), .mk_ready(mk_ready), .md_valid(md_valid), .md_op(md_op),
    .md_nco(md_nco), .md_arg(md_arg), .md_ready(md_ready), .group_flush(group_flush),
    .engines_idle(engines_idle));
  psqid_engine_model eng_u (.clk(clk), .nrst(nrst), .slow(slow), .wf_valid(wf_valid),
    .mk_valid(mk_valid), .wf_ready(wf_ready), .mk_ready(mk_ready), .md_ready(md_ready),
    .engines_idle(engines_idle));
  // =====================================
  // instruction memory, monitors, timeout
  always @(posedge clk) begin
    if (fetch_req && !fetch_valid) begin
      fetch_valid <= 1'b1;
      fetch_data <= imem[fetch_addr[5:0]];
    end else begin
      fetch_valid <= 1'b0;
      fetch_data <= ~fetch_data;
    end
    if (wf_valid && wf_ready) wq.push_back({wf_op, wf_hold, wf_count, wf_addr});
    if (wf_valid && wf_ready && wf_op == 2'h3) pf_seen <= wf_pf_len;
    if (mk_valid && mk_ready) mq.push_back({mk_op, mk_chan, mk_trans, mk_level, mk_count});
    if (md_valid && md_ready) dq.push_back({md_op, md_nco, md_arg});
    if (icache_pf_valid) iq.push_back({icache_pf_addr, icache_pf_len});
    if (group_flush) gn++;
    if (msg_pop) begin
      msg_valid <= 1'b0;
      msg_data <= ~msg_data;
    end
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
  // =====================================
  // tasks
  task chk(input string n, input logic [63:0] s, input logic [63:0] x);
    checks++;
    if (s !== x) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // =====================================
  // main sequence
  initial begin
    foreach (imem[i]) imem[i] = 64'h0;
    imem[0] = {8'h00, 8'h00, 2'h0, 1'b1, 21'h5, 24'h123456};
    imem[1] = {8'h1A, 8'h00, 2'h0, 9'h1FF, 4'hA, 1'b1, 32'h12345678};
    imem[2] = {8'hA0, 8'h00, 3'h3, 1'b1, 4'h3, 8'hFF, 32'h02AAAAAB};
    imem[3] = {8'h21, 8'h00, 2'h1, 46'h0};
    imem[4] = {8'h91, 8'h00, 2'h2, 46'h0};
    imem[5] = {8'h30, 40'h0, 16'h0002};
    imem[6] = {8'h00, 8'h00, 2'h0, 1'b0, 21'h7, 24'h10};
    imem[7] = {8'h40, 30'h0, 26'h6};
    imem[8] = {8'hB0, {56{1'b1}}};
    imem[9] = {8'h50, 46'h0, 2'h1, 8'h5A};
    imem[10] = {8'h60, 30'h0, 26'd30};
    imem[11] = {8'h70, 30'h0, 26'd14};
    imem[12] = {8'hC0, 30'h0, 26'h40};
    imem[13] = {8'h60, 30'h0, 26'd20};
    imem[14] = {8'h00, 8'h00, 2'h3, 1'b0, 21'h0, 24'h200};
    imem[15] = {8'h30, 40'h0, 16'h0005};
    imem[16] = {8'h80, {56{1'b1}}};
    imem[20] = {8'h50, 46'h0, 2'h2, 8'h59};
    imem[21] = {8'h60, 30'h0, 26'd23};
    imem[22] = {8'hC0, 30'h0, 26'h22};
    imem[23] = {8'h50, 46'h0, 2'h3, 8'h59};
    imem[24] = {8'h70, 30'h0, 26'd30};
    imem[25] = {8'h50, 46'h0, 2'h0, 8'h5A};
    imem[26] = {8'h60, 30'h0, 26'd26};
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, 12'h00C, 32'h0);
    chk("creg reset", r, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("repc reset", r, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped err", e, 1'b1);
    chk("unmapped data", r, 32'h0);
    $display("test registers done");
    apb(1'b1, 12'h014, 32'h0);
    apb(1'b1, 12'h000, 32'h1);
    repeat (300) @(posedge clk);
    chk("wf before msg", wq.size(), 5);
    chk("ipf before msg", iq.size(), 0);
    msg_valid <= 1'b1;
    msg_data <= 8'h5A;
    slow <= 1'b0;
    repeat (300) @(posedge clk);
    chk("wf count", wq.size(), 6);
    foreach (wx[i]) chk("wf op", wq[i], wx[i]);
    chk("mk count", mq.size(), 3);
    foreach (mx[i]) chk("mk op", mq[i], mx[i]);
    chk("md op", dq[0], {3'h3, 2'h3, 32'h02AAAAAB});
    chk("ipf", iq[0], {26'h40, 8'h80});
    chk("ipf count", iq.size(), 1);
    chk("wf pf len", pf_seen, 32'h00010000);
    chk("flush count", gn, 2);
    apb(1'b0, 12'h00C, 32'h0);
    chk("creg", r, 32'h5A);
    apb(1'b0, 12'h010, 32'h0);
    chk("repc", r, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk("stack empty", r[6], 1'b1);
    $display("test program done");
    end_sim();
  end
endmodule
